// ===== irq_pkg.sv
// shared constants for the interrupt acknowledge block
package irq_pkg;
  localparam int ADDR_W = 18;
  localparam int N_PIN = 4;
  localparam int N_PIN_B = 2;
  localparam int N_LVL = 6;
  localparam int PM_HALF = 7;
  localparam int CFG_W = 6;
  // register indices; byte address is four times the index
  localparam logic [15:0] XB1_IDX = 16'h7074;
  localparam logic [15:0] XB2_IDX = 16'h7076;
  localparam logic [15:0] XC1_IDX = 16'h7078;
  localparam logic [15:0] XC2_IDX = 16'h707a;
  localparam logic [15:0] PM1_IDX = 16'h707c;
  localparam logic [15:0] PM2_IDX = 16'h707e;
  localparam logic [15:0] IFR_IDX = 16'h7080;
  localparam logic [15:0] IMR_IDX = 16'h7081;
  localparam logic [15:0] CTL_IDX = 16'h7082;
  localparam logic [15:0] IDX_STEP = 16'h0002;
  // pin control fields
  localparam int FLAG_B = 15;
  localparam int NMI_B = 5;
  localparam int DIR_B = 4;
  localparam int DOUT_B = 3;
  localparam int POL_B = 2;
  localparam int PRI_B = 1;
  localparam int EN_B = 0;
  localparam logic [CFG_W-1:0] CFG_MASK_B = 6'h3f;
  localparam logic [CFG_W-1:0] CFG_MASK_C = 6'h1f;
  localparam logic [CFG_W-1:0] CFG_RST = 6'h00;
  // power irq fields
  localparam int PM_STS_LSB = 8;
  localparam int PM_EN_B = 7;
  // control register fields
  localparam int CTL_GLOBAL_IRQ_MASK_BIT_B = 0;
  localparam int CTL_DIV4_B = 1;
  // timing in core clocks / peripheral ticks
  localparam int RESP_CYC = 4;
  localparam int BRANCH_CYC = 4;
  localparam int EXT_SYNC_TICKS = 2;
  localparam logic [1:0] DIV2_LAST = 2'h1;
  localparam logic [1:0] DIV4_LAST = 2'h3;
  // acknowledge vector codes
  localparam logic [3:0] VEC_RST = 4'h0;
  localparam logic [3:0] VEC_LVL0 = 4'h1;
  localparam logic [3:0] VEC_NMI = 4'h7;
  localparam logic [3:0] VEC_TRAP = 4'h9;
endpackage : irq_pkg

// ===== pin_sync.sv
// three-stage pin synchroniser with agreed-level edge detection
`timescale 1ns/1ps
module pin_sync (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic pin,
  output logic level,
  output logic rise,
  output logic fall
);
  logic s1_ff, s2_ff, s3_ff, level_ff, rise_ff, fall_ff;
  logic agree;

  assign agree = s2_ff == s3_ff;

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      s1_ff <= 1'b0;
      s2_ff <= 1'b0;
      s3_ff <= 1'b0;
    end else begin
      s1_ff <= pin;
      s2_ff <= s1_ff;
      s3_ff <= s2_ff;
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      level_ff <= 1'b0;
      rise_ff <= 1'b0;
      fall_ff <= 1'b0;
    end else begin
      if (agree) begin
        level_ff <= s3_ff;
      end
      rise_ff <= agree & s3_ff & ~level_ff;
      fall_ff <= agree & ~s3_ff & level_ff;
    end
  end

  assign level = level_ff;
  assign rise = rise_ff;
  assign fall = fall_ff;
endmodule : pin_sync

// ===== irq_ack_core.sv
// cpu interrupt recognition and acknowledge with external and power irq control registers
// How it works
// - peripheral requests reach the flag register within one peripheral-bus tick
// - external pin requests wait two peripheral-bus ticks after synchronising
// - event manager requests reach the flag register two core clocks after the request
// - acknowledge to vector fetch takes four core clocks
// - maskable requests stay blocked by global mask; nonmaskable still taken
// - when blocking ends the highest pending request wins
// - repeat loop blocks all interrupts except hard reset
// - hard reset is never held off; nonmaskable may be
// - no interrupt between unmask instruction and the next instruction
// - after return, block until one instruction has executed
// - wait states stretch blocking and the vector fetch
// - pin flag always sets; flag register only if source enabled
// - maskable acknowledge needs global mask clear and mask bit set
// - maskable acknowledge clears flag bit, sets global mask
// - acknowledge other than hard reset pushes pc plus one; return pops it
// - nonmaskable requests acknowledged without testing masks
// - software irq leaves its flag register bit set
// - global mask set for all nonmaskable kinds except trap
// - external pins with programmable polarity and priority
// - two power irq registers with status, enables, flag and enable
// - vector branch phase lasts at least four cycles
// - polarity bit 0 falling edge, 1 rising edge
// - pin flag sets on every selected edge; an edge with enable or nonmaskable set requests, or restarts a pending wait
// - clearing a pin flag cancels its pending request
// - priority 0 high, 1 low; ignored with nonmaskable selection
//
// Added by the designer: register access over APB.
`timescale 1ns/1ps
module irq_ack_core #(
  parameter int HI_LVL = 0,
  parameter int LO_LVL = 1,
  parameter int PM_LVL = 2
) (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic [irq_pkg::ADDR_W-1:0] paddr,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  input wire logic [irq_pkg::N_PIN-1:0] ext_pin_in,
  output logic [irq_pkg::N_PIN-1:0] ext_pin_out,
  output logic [irq_pkg::N_PIN-1:0] ext_pin_oe,
  input wire logic [irq_pkg::N_LVL-1:0] periph_irq,
  input wire logic [irq_pkg::N_LVL-1:0] evm_irq,
  input wire logic [2*irq_pkg::PM_HALF-1:0] pm_src,
  input wire logic hard_reset_req,
  input wire logic nmi_instr_req,
  input wire logic swi_req,
  input wire logic [2:0] swi_level,
  input wire logic trap_req,
  input wire logic rpt_active,
  input wire logic multicycle_busy,
  input wire logic mem_ready,
  input wire logic instr_done,
  input wire logic clear_control_bit_instruction_global_irq_mask_bit_exec,
  input wire logic ret_exec,
  input wire logic [15:0] pc,
  output logic irq_ack,
  output logic ack_maskable,
  output logic [3:0] ack_vector,
  output logic pipe_flush,
  output logic vec_fetch,
  output logic isr_enter,
  output logic stack_push,
  output logic [15:0] push_addr,
  output logic stack_pop,
  output logic global_irq_mask_bit
);
  import irq_pkg::*;

  typedef enum logic [1:0] {st_run, st_resp, st_vec} cpu_state_t;

  localparam logic [2:0] RESP_LAST = 3'(RESP_CYC - 1);
  localparam logic [2:0] BR_LAST = 3'(BRANCH_CYC - 1);
  localparam logic [1:0] EXT_LAST = 2'(EXT_SYNC_TICKS - 1);

  cpu_state_t state_ff;
  logic [2:0] cnt_ff;
  logic [1:0] div_cnt_ff;
  logic div4_ff, global_irq_mask_bit_ff, nxt_global_irq_mask_bit, sys_tick;
  logic [N_LVL-1:0] ifr_ff, imr_ff, int_pend_ff, evm_d_ff;
  logic [N_LVL-1:0] int_req, ifr_set, ifr_clr, ext_lvl_set, pend_mask;
  logic [2:0] sel_lvl, swi_lvl_ff;
  logic nmi_pend_ff, swi_pend_ff, trap_pend_ff, clear_control_bit_instruction_hold_ff, ret_hold_ff;
  logic ext_nmi, blocked, take_rst, take_nmi, take_swi, take_trap, take_mask, take_any;
  logic ack_ff, ackm_ff, flush_ff, fetch_ff, enter_ff, push_ff, pop_ff;
  logic [3:0] vec_ff;
  logic [15:0] push_addr_ff, widx, rd_val;
  logic [31:0] rdata_ff;
  logic wr_en, hit;
  logic [N_PIN-1:0] pin_lvl, pin_rise, pin_fall, pin_flag, pin_fwd;
  logic [N_PIN-1:0][CFG_W-1:0] pin_cfg;
  logic [1:0] pm_req;
  logic [1:0][15:0] pm_rd;

  // peripheral-bus tick, core clock divided by two or four
  assign sys_tick = div_cnt_ff == (div4_ff ? DIV4_LAST : DIV2_LAST);

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      div_cnt_ff <= 2'h0;
    end else if (sys_tick) begin
      div_cnt_ff <= 2'h0;
    end else begin
      div_cnt_ff <= div_cnt_ff + 2'h1;
    end
  end

  // apb slave, zero wait states
  assign widx = paddr[ADDR_W-1:2];
  assign wr_en = psel & penable & pwrite;
  assign pready = 1'b1;
  assign pslverr = psel & penable & ~hit;
  assign prdata = rdata_ff;

  // external pins
  for (genvar i = 0; i < N_PIN; i++) begin : g_pin
    localparam logic [15:0] MY_IDX = XB1_IDX + 16'(i * 2);
    localparam logic [CFG_W-1:0] WMASK = (i < N_PIN_B) ? CFG_MASK_B : CFG_MASK_C;
    logic [CFG_W-1:0] cfg_ff;
    logic flag_ff, pend_ff, wr_me, clr_flag, edge_sel;
    logic [1:0] pcnt_ff;

    pin_sync u_sync (
      .pclk(pclk),
      .presetn(presetn),
      .pin(ext_pin_in[i]),
      .level(pin_lvl[i]),
      .rise(pin_rise[i]),
      .fall(pin_fall[i])
    );

    assign wr_me = wr_en && (widx == MY_IDX);
    assign clr_flag = wr_me & pwdata[FLAG_B];
    assign edge_sel = cfg_ff[POL_B] ? pin_rise[i] : pin_fall[i];

    always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
        cfg_ff <= CFG_RST;
      end else if (wr_me) begin
        cfg_ff <= pwdata[CFG_W-1:0] & WMASK;
      end
    end

    // edge wins over a clearing write in the same cycle
    always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
        flag_ff <= 1'b0;
      end else if (edge_sel) begin
        flag_ff <= 1'b1;
      end else if (clr_flag) begin
        flag_ff <= 1'b0;
      end
    end

    always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
        pend_ff <= 1'b0;
        pcnt_ff <= 2'h0;
      end else if (edge_sel && (cfg_ff[EN_B] || cfg_ff[NMI_B])) begin
        pend_ff <= 1'b1;
        pcnt_ff <= 2'h0;
      end else if (clr_flag) begin
        pend_ff <= 1'b0;
      end else if (pend_ff && sys_tick) begin
        if (pcnt_ff == EXT_LAST) begin
          pend_ff <= 1'b0;
        end
        pcnt_ff <= pcnt_ff + 2'h1;
      end
    end

    assign pin_fwd[i] = pend_ff & sys_tick & (pcnt_ff == EXT_LAST);
    assign pin_cfg[i] = cfg_ff;
    assign pin_flag[i] = flag_ff;
    assign ext_pin_oe[i] = cfg_ff[DIR_B] & ~cfg_ff[EN_B] & ~cfg_ff[NMI_B];
    assign ext_pin_out[i] = cfg_ff[DOUT_B];
  end

  always_comb begin
    ext_lvl_set = '0;
    ext_nmi = 1'b0;
    for (int i = 0; i < N_PIN; i++) begin
      if (pin_fwd[i]) begin
        if (pin_cfg[i][NMI_B]) begin
          ext_nmi = 1'b1;
        end else if (pin_cfg[i][EN_B]) begin
          if (pin_cfg[i][PRI_B]) begin
            ext_lvl_set[LO_LVL] = 1'b1;
          end else begin
            ext_lvl_set[HI_LVL] = 1'b1;
          end
        end
      end
    end
  end

  // power irq registers: half 0 holds sources 13..7, half 1 sources 6..0
  for (genvar h = 0; h < 2; h++) begin : g_pm
    localparam int LSB = (1 - h) * PM_HALF;
    localparam logic [15:0] MY_IDX = PM1_IDX + 16'(h * 2);
    logic [PM_HALF-1:0] sts_ff, en_ff, src_hit;
    logic flag_ff, ren_ff, wr_me;

    assign wr_me = wr_en && (widx == MY_IDX);
    assign src_hit = pm_src[LSB+:PM_HALF] & en_ff;

    always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
        sts_ff <= '0;
      end else begin
        sts_ff <= (sts_ff & ~(wr_me ? pwdata[PM_STS_LSB+:PM_HALF] : '0)) | pm_src[LSB+:PM_HALF];
      end
    end

    always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
        en_ff <= '0;
        ren_ff <= 1'b0;
      end else if (wr_me) begin
        en_ff <= pwdata[PM_HALF-1:0];
        ren_ff <= pwdata[PM_EN_B];
      end
    end

    always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
        flag_ff <= 1'b0;
      end else if (|src_hit) begin
        flag_ff <= 1'b1;
      end else if (wr_me && pwdata[FLAG_B]) begin
        flag_ff <= 1'b0;
      end
    end

    assign pm_req[h] = ren_ff & (|src_hit);
    assign pm_rd[h] = {flag_ff, sts_ff, ren_ff, en_ff};
  end

  // internal requests held until the next peripheral-bus tick
  always_comb begin
    int_req = periph_irq;
    int_req[PM_LVL] = periph_irq[PM_LVL] | (|pm_req);
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      int_pend_ff <= '0;
      evm_d_ff <= '0;
    end else begin
      int_pend_ff <= sys_tick ? '0 : (int_pend_ff | int_req);
      evm_d_ff <= evm_irq;
    end
  end

  // flag register: hardware sets win over clears
  always_comb begin
    ifr_set = ext_lvl_set | evm_d_ff | (sys_tick ? (int_pend_ff | int_req) : '0);
    ifr_clr = (wr_en && widx == IFR_IDX) ? pwdata[N_LVL-1:0] : '0;
    if (take_mask) begin
      ifr_clr[sel_lvl] = 1'b1;
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      ifr_ff <= '0;
    end else begin
      ifr_ff <= (ifr_ff & ~ifr_clr) | ifr_set;
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      imr_ff <= '0;
      div4_ff <= 1'b0;
    end else begin
      if (wr_en && widx == IMR_IDX) begin
        imr_ff <= pwdata[N_LVL-1:0];
      end
      if (wr_en && widx == CTL_IDX) begin
        div4_ff <= pwdata[CTL_DIV4_B];
      end
    end
  end

  // lowest level number is highest priority
  assign pend_mask = ifr_ff & imr_ff;

  always_comb begin
    sel_lvl = 3'h0;
    for (int k = N_LVL - 1; k >= 0; k--) begin
      if (pend_mask[k]) begin
        sel_lvl = 3'(k);
      end
    end
  end

  // the unmask and return instructions block in their own cycle too
  assign blocked = rpt_active | multicycle_busy | ~mem_ready | clear_control_bit_instruction_global_irq_mask_bit_exec | ret_exec
    | clear_control_bit_instruction_hold_ff | ret_hold_ff | (state_ff != st_run);
  assign take_rst = hard_reset_req;
  assign take_nmi = ~take_rst & ~blocked & nmi_pend_ff;
  assign take_swi = ~take_rst & ~blocked & ~nmi_pend_ff & swi_pend_ff;
  assign take_trap = ~take_rst & ~blocked & ~nmi_pend_ff & ~swi_pend_ff & trap_pend_ff;
  assign take_mask = ~take_rst & ~blocked & ~nmi_pend_ff & ~swi_pend_ff & ~trap_pend_ff
    & ~global_irq_mask_bit_ff & (|pend_mask);
  assign take_any = take_rst | take_nmi | take_swi | take_trap | take_mask;

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      nmi_pend_ff <= 1'b0;
      swi_pend_ff <= 1'b0;
      swi_lvl_ff <= 3'h0;
      trap_pend_ff <= 1'b0;
    end else begin
      nmi_pend_ff <= ext_nmi | nmi_instr_req | (nmi_pend_ff & ~take_nmi);
      swi_pend_ff <= swi_req | (swi_pend_ff & ~take_swi);
      trap_pend_ff <= trap_req | (trap_pend_ff & ~take_trap);
      if (swi_req) begin
        swi_lvl_ff <= swi_level;
      end
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      clear_control_bit_instruction_hold_ff <= 1'b0;
      ret_hold_ff <= 1'b0;
    end else begin
      clear_control_bit_instruction_hold_ff <= clear_control_bit_instruction_global_irq_mask_bit_exec | (clear_control_bit_instruction_hold_ff & ~instr_done);
      ret_hold_ff <= ret_exec | (ret_hold_ff & ~instr_done);
    end
  end

  always_comb begin
    nxt_global_irq_mask_bit = global_irq_mask_bit_ff;
    if (wr_en && widx == CTL_IDX) begin
      nxt_global_irq_mask_bit = pwdata[CTL_GLOBAL_IRQ_MASK_BIT_B];
    end
    if (take_any && !take_trap) begin
      nxt_global_irq_mask_bit = 1'b1;
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      global_irq_mask_bit_ff <= 1'b1;
    end else begin
      global_irq_mask_bit_ff <= nxt_global_irq_mask_bit;
    end
  end

  // acknowledge, flush, vector fetch, branch
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      state_ff <= st_run;
      cnt_ff <= 3'h0;
    end else if (take_any) begin
      state_ff <= st_resp;
      cnt_ff <= 3'h0;
    end else begin
      unique case (state_ff)
        st_run: cnt_ff <= 3'h0;
        st_resp: begin
          cnt_ff <= (cnt_ff == RESP_LAST) ? 3'h0 : cnt_ff + 3'h1;
          if (cnt_ff == RESP_LAST) begin
            state_ff <= st_vec;
          end
        end
        st_vec: begin
          if (mem_ready) begin
            cnt_ff <= cnt_ff + 3'h1;
            if (cnt_ff == BR_LAST) begin
              state_ff <= st_run;
            end
          end
        end
      endcase
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      ack_ff <= 1'b0;
      ackm_ff <= 1'b0;
      vec_ff <= VEC_RST;
      flush_ff <= 1'b0;
      fetch_ff <= 1'b0;
      enter_ff <= 1'b0;
    end else begin
      ack_ff <= take_any;
      ackm_ff <= take_mask;
      flush_ff <= take_any;
      fetch_ff <= ~take_any & (state_ff == st_resp) & (cnt_ff == RESP_LAST);
      enter_ff <= ~take_any & (state_ff == st_vec) & mem_ready & (cnt_ff == BR_LAST);
      if (take_any) begin
        vec_ff <= take_rst ? VEC_RST : take_nmi ? VEC_NMI : take_trap ? VEC_TRAP
          : VEC_LVL0 + {1'b0, take_swi ? swi_lvl_ff : sel_lvl};
      end
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      push_ff <= 1'b0;
      push_addr_ff <= 16'h0000;
      pop_ff <= 1'b0;
    end else begin
      push_ff <= take_any & ~take_rst;
      pop_ff <= ret_exec;
      if (take_any) begin
        push_addr_ff <= pc + 16'h0001;
      end
    end
  end

  // register readback, latched in the setup phase
  always_comb begin
    hit = 1'b1;
    rd_val = 16'h0000;
    unique case (widx)
      XB1_IDX, XB2_IDX, XC1_IDX, XC2_IDX: begin
        for (int i = 0; i < N_PIN; i++) begin
          if (widx == XB1_IDX + 16'(i * 2)) begin
            rd_val = {pin_flag[i], 8'h00, pin_lvl[i], pin_cfg[i]};
          end
        end
      end
      PM1_IDX: rd_val = pm_rd[0];
      PM2_IDX: rd_val = pm_rd[1];
      IFR_IDX: rd_val = {10'h000, ifr_ff};
      IMR_IDX: rd_val = {10'h000, imr_ff};
      CTL_IDX: rd_val = {14'h0000, div4_ff, global_irq_mask_bit_ff};
      default: hit = 1'b0;
    endcase
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      rdata_ff <= 32'h0000_0000;
    end else if (psel && !penable) begin
      rdata_ff <= {16'h0000, rd_val};
    end
  end

  assign irq_ack = ack_ff;
  assign ack_maskable = ackm_ff;
  assign ack_vector = vec_ff;
  assign pipe_flush = flush_ff;
  assign vec_fetch = fetch_ff;
  assign isr_enter = enter_ff;
  assign stack_push = push_ff;
  assign push_addr = push_addr_ff;
  assign stack_pop = pop_ff;
  assign global_irq_mask_bit = global_irq_mask_bit_ff;

  property p_resp_len;
    @(posedge pclk) disable iff (!presetn)
    (irq_ack && !hard_reset_req) ##1 (!hard_reset_req) [*3] |=> vec_fetch;
  endproperty
  a_resp_len: assert property (p_resp_len) else $error("vector fetch not four cycles after ack");

  property p_mask_ok;
    @(posedge pclk) disable iff (!presetn)
    ack_maskable |-> !$past(global_irq_mask_bit) && global_irq_mask_bit;
  endproperty
  a_mask_ok: assert property (p_mask_ok) else $error("maskable ack with global mask set");

  property p_global_irq_mask_bit_set;
    @(posedge pclk) disable iff (!presetn)
    irq_ack && ack_vector != VEC_TRAP |-> global_irq_mask_bit;
  endproperty
  a_global_irq_mask_bit_set: assert property (p_global_irq_mask_bit_set) else $error("global mask not set on ack");

  property p_rpt_block;
    @(posedge pclk) disable iff (!presetn)
    rpt_active && !hard_reset_req |=> !irq_ack;
  endproperty
  a_rpt_block: assert property (p_rpt_block) else $error("ack during repeat loop");

  property p_rst_now;
    @(posedge pclk) disable iff (!presetn)
    hard_reset_req |=> irq_ack && ack_vector == VEC_RST;
  endproperty
  a_rst_now: assert property (p_rst_now) else $error("hard reset not taken at once");

  property p_push;
    @(posedge pclk) disable iff (!presetn)
    take_any && !take_rst |=> stack_push && push_addr == 16'($past(pc) + 16'h0001);
  endproperty
  a_push: assert property (p_push) else $error("return address not pushed");

  property p_ret_hold;
    @(posedge pclk) disable iff (!presetn)
    (ret_exec || ret_hold_ff || clear_control_bit_instruction_global_irq_mask_bit_exec || clear_control_bit_instruction_hold_ff) && !hard_reset_req |=> !irq_ack;
  endproperty
  a_ret_hold: assert property (p_ret_hold) else $error("ack inside return or unmask window");

  property p_evm;
    @(posedge pclk) disable iff (!presetn)
    evm_irq[0] |-> ##2 ifr_ff[0];
  endproperty
  a_evm: assert property (p_evm) else $error("event manager request late");

  property p_periph;
    @(posedge pclk) disable iff (!presetn)
    periph_irq[HI_LVL] |-> ##[1:4] ifr_ff[HI_LVL];
  endproperty
  a_periph: assert property (p_periph) else $error("peripheral request not forwarded");
endmodule : irq_ack_core

// ===== irq_src_model.sv
// far-side model: external pin drivers resolved against the block's own drivers
`timescale 1ns/1ps
module irq_src_model (
  input wire logic [irq_pkg::N_PIN-1:0] pin_lvl,
  input wire logic [irq_pkg::N_PIN-1:0] ext_pin_out,
  input wire logic [irq_pkg::N_PIN-1:0] ext_pin_oe,
  output logic [irq_pkg::N_PIN-1:0] ext_pin_in
);
  import irq_pkg::*;
  // block wins where it drives, so the pin never floats to x
  assign ext_pin_in = (ext_pin_oe & ext_pin_out) | (~ext_pin_oe & pin_lvl);
endmodule : irq_src_model

// ===== cpu_interrupt_acknowledge_latency_tb_top.sv
// self-checking bench for the interrupt acknowledge block
`timescale 1ns/1ps
module cpu_interrupt_acknowledge_latency_tb_top;
  import irq_pkg::*;
  logic pclk, presetn, psel, penable, pwrite, pready, pslverr, err_q, m;
  logic [ADDR_W-1:0] paddr;
  logic [31:0] pwdata, prdata, rd_q, rnd_state, r;
  logic [N_PIN-1:0] pin_lvl, pin_in, pin_out, pin_oe;
  logic [N_LVL-1:0] periph, evm;
  logic [2*PM_HALF-1:0] pm;
  logic [6:0] ev;
  logic [1:0] blk;
  logic [2:0] swi_lvl;
  logic [15:0] pc, push_addr, ix;
  logic irq_ack, ack_mk, flush, vec_fetch, isr_enter, push, pop, gmask;
  logic [3:0] ack_vector;
  int mismatches, checks_done, lvl, p, a, b;

  irq_src_model i_src (.pin_lvl(pin_lvl), .ext_pin_out(pin_out), .ext_pin_oe(pin_oe), .ext_pin_in(pin_in));
  irq_ack_core i_dut (.pclk(pclk), .presetn(presetn), .paddr(paddr), .psel(psel), .penable(penable),
    .pwrite(pwrite), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .ext_pin_in(pin_in), .ext_pin_out(pin_out), .ext_pin_oe(pin_oe), .periph_irq(periph),
    .evm_irq(evm), .pm_src(pm), .hard_reset_req(ev[0]), .nmi_instr_req(ev[1]),
    .swi_req(ev[3]), .swi_level(swi_lvl), .trap_req(ev[2]), .rpt_active(blk[0]),
    .multicycle_busy(blk[1]), .mem_ready(~blk[1]), .instr_done(ev[6]), .clear_control_bit_instruction_global_irq_mask_bit_exec(ev[5]),
    .ret_exec(ev[4]), .pc(pc), .irq_ack(irq_ack), .ack_maskable(ack_mk), .ack_vector(ack_vector),
    .pipe_flush(flush), .vec_fetch(vec_fetch), .isr_enter(isr_enter), .stack_push(push),
    .push_addr(push_addr), .stack_pop(pop), .global_irq_mask_bit(gmask));

  function automatic logic [31:0] rnd();
    rnd_state = rnd_state ^ (rnd_state << 13);
    rnd_state = rnd_state ^ (rnd_state >> 17);
    rnd_state = rnd_state ^ (rnd_state << 5);
    return rnd_state;
  endfunction : rnd

  function automatic logic [3:0] exp_vec(input int k);
    case (k)
      0: return VEC_RST;
      1: return VEC_NMI;
      2: return VEC_TRAP;
      default: return VEC_LVL0 + 4'(swi_lvl);
    endcase
  endfunction : exp_vec

  // lowest level index wins
  function automatic logic [3:0] lvl_vec(input logic [5:0] req);
    for (int i = 5; i >= 0; i--) begin
      if (req[i]) lvl_vec = VEC_LVL0 + 4'(i);
    end
  endfunction : lvl_vec

  function automatic logic [31:0] pin_exp(input logic f, input logic l, input int pol);
    return {16'h0, f, 8'h0, l, 3'h0, pol[0], 2'h0};
  endfunction : pin_exp

  task automatic cmp(input string n, input logic [31:0] e, input logic [31:0] s);
    checks_done++;
    if (s !== e) begin
      mismatches++;
      $display("[FAIL] %s expected %h seen %h", n, e, s);
    end
  endtask : cmp

  task automatic apb(input logic w, input logic [15:0] i, input logic [31:0] d);
    @(posedge pclk);
    psel <= 1'h1;
    pwrite <= w;
    paddr <= {i, 2'h0};
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'h1;
    do @(posedge pclk); while (pready !== 1'h1);
    rd_q = prdata;
    err_q = pslverr;
    psel <= 1'h0;
    penable <= 1'h0;
  endtask : apb

  task automatic pulse(input int k);
    @(posedge pclk);
    ev <= 7'h1 << k;
    @(posedge pclk);
    ev <= 7'h0;
  endtask : pulse

  task automatic preq(input logic [5:0] q);
    @(posedge pclk);
    // event manager and peripheral paths both feed the flag register
    if (rnd_state[3]) periph <= q;
    else evm <= q;
    @(posedge pclk);
    periph <= 6'h0;
    evm <= 6'h0;
  endtask : preq

  task automatic no_ack(input int n);
    repeat (n) begin
      @(posedge pclk);
      cmp("irq_ack", 0, irq_ack);
    end
  endtask : no_ack

  task automatic chk_ack(input logic [3:0] vec, input logic mk, input logic gm);
    int n;
    n = 0;
    do begin
      @(posedge pclk);
      n++;
    end while (irq_ack !== 1'h1 && n < 16);
    cmp("irq_ack", 1, irq_ack);
    cmp("pipe_flush", 1, flush);
    cmp("ack_vector", vec, ack_vector);
    cmp("ack_maskable", mk, ack_mk);
    cmp("stack_push", vec != VEC_RST, push);
    if (vec != VEC_RST) cmp("push_addr", pc + 16'h1, push_addr);
    repeat (4) @(posedge pclk);
    cmp("vec_fetch", 1, vec_fetch);
    repeat (4) @(posedge pclk);
    cmp("isr_enter", 1, isr_enter);
    cmp("global mask", gm, gmask);
  endtask : chk_ack

  task automatic give_verdict;
    $display("checks %0d mismatches %0d", checks_done, mismatches);
    if (mismatches == 0 && checks_done > 0)
      $display("No errors found");
    else
      $display("Errors were found");
    $finish;
  endtask : give_verdict

  initial begin
    pclk = 1'h0;
    forever #2.5 pclk = ~pclk;
  end

  initial begin
    repeat (20000) @(posedge pclk);
    mismatches++;
    give_verdict();
  end

  initial begin
    {presetn, psel, penable, pwrite, paddr, pwdata, pin_lvl, periph, evm, pm, ev, blk, swi_lvl, pc} = '0;
    rnd_state = 32'h60;
    repeat (5) @(posedge pclk);
    presetn <= 1'h1;
    cmp("global mask", 1, gmask);
    apb(1'h0, CTL_IDX, 0);
    cmp("control", 32'h1, rd_q);
    for (int i = 0; i < 6; i++) begin
      apb(1'h0, XB1_IDX + IDX_STEP * 16'(i), 0);
      cmp("control reg", 0, rd_q);
    end
    apb(1'h0, 16'h7000, 0);
    cmp("slave error", 1, err_q);
    // masked first, then unmasked: the flag must survive the wait
    for (int i = 0; i < 4; i++) begin
      r = rnd();
      lvl = (i == 0) ? 5 : int'(r % 6);
      pc <= r[31:16];
      apb(1'h1, CTL_IDX, 32'(i % 2) << 1);
      apb(1'h1, IMR_IDX, 0);
      preq(6'h1 << lvl);
      no_ack(12);
      apb(1'h0, IFR_IDX, 0);
      cmp("irq flags", 32'h1 << lvl, rd_q);
      apb(1'h1, IMR_IDX, 32'h1 << lvl);
      chk_ack(VEC_LVL0 + 4'(lvl), 1'h1, 1'h1);
      apb(1'h0, IFR_IDX, 0);
      cmp("irq flags", 0, rd_q);
    end
    // mask register cleared so no maskable ack can overtake the event under test
    apb(1'h1, IMR_IDX, 0);
    for (int k = 3; k >= 0; k--) begin
      r = rnd();
      m = r[0];
      lvl = int'(r[15:8] % 6);
      apb(1'h1, CTL_IDX, {31'h0, m});
      apb(1'h1, IFR_IDX, 32'h3f);
      preq(6'h1 << lvl);
      pc <= r[31:16];
      swi_lvl <= 3'(lvl);
      pulse(k);
      chk_ack(exp_vec(k), 1'h0, (k == 2) ? m : 1'h1);
      apb(1'h0, IFR_IDX, 0);
      if (k > 0) cmp("irq flags", 32'h1 << lvl, rd_q);
    end
    // blockers: repeat loop, multicycle, return, unmask instruction
    for (int j = 0; j < 4; j++) begin
      r = rnd();
      a = int'(r[7:0] % 6);
      b = (j == 0) ? 0 : int'(r[15:8] % 6);
      apb(1'h1, IFR_IDX, 32'h3f);
      apb(1'h1, IMR_IDX, 32'h3f);
      apb(1'h1, CTL_IDX, 0);
      if (j < 2) blk[j] <= 1'h1;
      else pulse(j + 2);
      @(posedge pclk);
      if (j == 2) cmp("stack_pop", 1, pop);
      preq((6'h1 << a) | (6'h1 << b));
      case (j)
        0: no_ack(12);
        1: no_ack(12);
        2: no_ack(12);
        default: no_ack(12);
      endcase
      if (j < 2) blk[j] <= 1'h0;
      else pulse(6);
      chk_ack(lvl_vec((6'h1 << a) | (6'h1 << b)), 1'h1, 1'h1);
    end
    for (int pol = 0; pol < 2; pol++) begin
      r = rnd();
      p = int'(r % 4);
      ix = XB1_IDX + IDX_STEP * 16'(p);
      pin_lvl[p] <= pol[0];
      repeat (10) @(posedge pclk);
      apb(1'h1, ix, 32'h8000 | (pol << 2));
      pin_lvl[p] <= ~pol[0];
      repeat (10) @(posedge pclk);
      apb(1'h0, ix, 0);
      cmp("pin control", pin_exp(1'h0, ~pol[0], pol), rd_q);
      pin_lvl[p] <= pol[0];
      repeat (10) @(posedge pclk);
      apb(1'h0, ix, 0);
      cmp("pin control", pin_exp(1'h1, pol[0], pol), rd_q);
    end
    apb(1'h1, ix, 32'h18);
    @(posedge pclk);
    cmp("pin drive", 2'h3, {pin_oe[p], pin_out[p]});
    apb(1'h1, ix, 32'h19);
    @(posedge pclk);
    cmp("pin drive", 2'h1, {pin_oe[p], pin_out[p]});
    p = int'(r[11:8] % 7);
    apb(1'h1, PM2_IDX, 32'h80 | (32'h1 << p));
    @(posedge pclk);
    pm <= 14'h1 << p;
    @(posedge pclk);
    pm <= 14'h0;
    apb(1'h0, PM2_IDX, 0);
    cmp("power lower", 32'h8080 | (32'h101 << p), rd_q);
    apb(1'h0, IFR_IDX, 0);
    cmp("power irq flag", 1, rd_q[2]);
    blk[0] <= 1'h1;
    pulse(1);
    no_ack(12);
    pulse(0);
    chk_ack(VEC_RST, 1'h0, 1'h1);
    give_verdict();
  end
endmodule : cpu_interrupt_acknowledge_latency_tb_top
